/* dac_pkg.sv */
// Shared constants and types for the quad converter serial load path
package dac_pkg;

  // ----------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 24;
  localparam int CODE_BITS = 16;
  localparam int CHANNELS = 4;
  localparam int CHANNEL_ADDR_HI_POS = 23;
  localparam int CHANNEL_ADDR_LO_POS = 22;
  localparam int BROADCAST_POS = 21;
  localparam int CODE_MSB_POS = 15;
  localparam int BIT_CNT_W = 5;
  localparam logic [BIT_CNT_W-1:0] LAST_BIT_IDX = 5'h17;
  localparam logic [4:0] UNUSED_BITS_VALUE = 5'h00;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [CODE_BITS-1:0] MIDSCALE_CODE = 16'h8000;
  localparam logic [CODE_BITS-1:0] ZEROSCALE_CODE = 16'h0000;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ = 250_000_000;
  localparam int SCLK_HZ = 4_000_000;
  localparam int SCLK_HALF_CYC = CLK_HZ / (2 * SCLK_HZ);
  localparam int STROBE_NS = 5000;
  localparam int STROBE_CYC = (STROBE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int TIMER_W = 11;

  // ----------------------------------------------------------------
  // Host sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE     = 3'h0,
    ST_SELECT   = 3'h1,
    ST_SHIFT    = 3'h2,
    ST_DESELECT = 3'h3,
    ST_LOAD     = 3'h4,
    ST_GAP      = 3'h5,
    ST_UPDATE   = 3'h6
  } host_state_e;

endpackage

/* dac_link_if.sv */
// Serial link and strobe pins between the host and the converter
`timescale 1ns/1ns
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic cs_n;
  logic sdi;
  logic load_n;
  logic output_update_strobe;
  logic reset_n;
  logic reset_level_select;

  modport host (
    output sclk, cs_n, sdi, load_n, output_update_strobe, reset_n, reset_level_select
  );
  modport device (
    input sclk, cs_n, sdi, load_n, output_update_strobe, reset_n, reset_level_select
  );
endinterface
`default_nettype wire

/* word_buffer.sv */
// Small valid/ready buffer for command words
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 19,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_ptr_q;
  logic [PTR_W-1:0] rd_ptr_q;
  logic [PTR_W:0] count_q;

  wire push = in_valid_i && in_ready_o && ce_i;
  wire pop = out_valid_o && out_ready_i && ce_i;

  assign in_ready_o = (count_q != (PTR_W+1)'(DEPTH));
  assign out_valid_o = (count_q != '0);
  assign out_data_o = mem_q[rd_ptr_q];

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end else begin
      if (push) wr_ptr_q <= bump(wr_ptr_q);
      if (pop) rd_ptr_q <= bump(rd_ptr_q);
      if (push && !pop) count_q <= count_q + 1'b1;
      else if (pop && !push) count_q <= count_q - 1'b1;
    end
  end
endmodule
`default_nettype wire

/* host_ctrl.sv */
// Host end: builds command words and drives the serial link and strobes
`timescale 1ns/1ns
`default_nettype none
module host_ctrl
  import dac_pkg::*;
#(
  parameter int BUF_DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  input wire logic [1:0] channel_addr_i,
  input wire logic broadcast_i,
  input wire logic [CODE_BITS-1:0] code_i,
  output logic busy_o,
  output logic done_o,
  dac_link_if.host link
);
  localparam int CMD_W = 2 + 1 + CODE_BITS;
  localparam logic [TIMER_W-1:0] HALF_LOAD = TIMER_W'(SCLK_HALF_CYC - 1);
  localparam logic [TIMER_W-1:0] STROBE_LOAD = TIMER_W'(STROBE_CYC - 1);

  // ----------------------------------------------------------------
  // Command buffer
  // ----------------------------------------------------------------
  logic cmd_valid;
  logic [CMD_W-1:0] cmd_data;
  host_state_e state_q;
  wire cmd_take = (state_q == ST_IDLE) && cmd_valid;

  word_buffer #(.WIDTH(CMD_W), .DEPTH(BUF_DEPTH)) u_buf (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .in_valid_i(word_valid_i),
    .in_ready_o(word_ready_o),
    .in_data_i({channel_addr_i, broadcast_i, code_i}),
    .out_valid_o(cmd_valid),
    .out_ready_i(cmd_take),
    .out_data_o(cmd_data)
  );

  // Unused positions are sent as zero
  wire [WORD_BITS-1:0] cmd_word = {cmd_data[CMD_W-1 -: 3], UNUSED_BITS_VALUE, cmd_data[CODE_BITS-1:0]};

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_q;
  logic [BIT_CNT_W-1:0] bit_q;
  logic [TIMER_W-1:0] tmr_q;
  logic sclk_q;
  logic cs_n_q;
  logic sdi_q;
  logic load_n_q;
  logic update_q;
  logic done_q;

  wire tmr_zero = (tmr_q == '0);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      shift_q <= '0;
      bit_q <= '0;
      tmr_q <= '0;
      sclk_q <= 1'b1;
      cs_n_q <= 1'b1;
      sdi_q <= 1'b0;
      load_n_q <= 1'b1;
      update_q <= 1'b1;
      done_q <= 1'b0;
    end else if (ce_i) begin
      done_q <= 1'b0;
      tmr_q <= tmr_zero ? tmr_q : tmr_q - 1'b1;
      case (state_q)
        ST_IDLE: begin
          if (cmd_valid) begin
            shift_q <= cmd_word;
            bit_q <= '0;
            cs_n_q <= 1'b0;
            tmr_q <= HALF_LOAD;
            state_q <= ST_SELECT;
          end
        end
        ST_SELECT: begin
          if (tmr_zero) begin
            state_q <= ST_SHIFT;
          end
        end
        ST_SHIFT: begin
          if (tmr_zero) begin
            tmr_q <= HALF_LOAD;
            if (sclk_q) begin
              sclk_q <= 1'b0;
              sdi_q <= shift_q[WORD_BITS-1];
            end else begin
              sclk_q <= 1'b1;
              shift_q <= {shift_q[WORD_BITS-2:0], 1'b0};
              bit_q <= bit_q + 1'b1;
              // Three bytes run back to back in one select period
              if (bit_q == LAST_BIT_IDX) begin
                state_q <= ST_DESELECT;
              end
            end
          end
        end
        ST_DESELECT: begin
          if (tmr_zero) begin
            cs_n_q <= 1'b1;
            load_n_q <= 1'b0;
            tmr_q <= STROBE_LOAD;
            state_q <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          if (tmr_zero) begin
            load_n_q <= 1'b1;
            tmr_q <= STROBE_LOAD;
            state_q <= ST_GAP;
          end
        end
        ST_GAP: begin
          if (tmr_zero) begin
            update_q <= 1'b0;
            tmr_q <= STROBE_LOAD;
            state_q <= ST_UPDATE;
          end
        end
        ST_UPDATE: begin
          if (tmr_zero) begin
            update_q <= 1'b1;
            done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign link.sclk = sclk_q;
  assign link.cs_n = cs_n_q;
  assign link.sdi = sdi_q;
  assign link.load_n = load_n_q;
  assign link.output_update_strobe = update_q;
  assign link.reset_n = 1'b1;
  assign link.reset_level_select = 1'b1;
  assign busy_o = (state_q != ST_IDLE);
  assign done_o = done_q;
endmodule
`default_nettype wire

/* quad_dac_device.sv */
// Converter end: serial shift register, input registers and output registers
//
// Notes on behaviour
// - Each command is 24 bits, MSB first.
// - Host sends three bytes per select period.
// - Bits 23 and 22 pick the channel.
// - Load strobe low writes the addressed register.
// - Broadcast bit set loads all four registers.
// - Broadcast bit clear loads only the addressed one.
// - Five bits ignored; last sixteen are code.
// - Rising serial clock shifts; 24th rise ends word.
// - Framed mode: clock idles high, pulses only selected.
// - Select held low: exactly 24 clocks per word.
// - Input registers follow while load strobe low.
// - Host keeps load strobe high while shifting.
// - Update strobe rising copies all inputs to outputs.
// - Reset with level select high gives 8000h.
// - Host holds reset and level select high.
// - Host pulses load, then update, after deselect.
// - Reference serial clock is about 4 MHz.
`timescale 1ns/1ns
`default_nettype none
module quad_dac_device
  import dac_pkg::*;
#(
  parameter int NUM_CHANNELS = CHANNELS
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  dac_link_if.device link,
  output logic [NUM_CHANNELS-1:0][CODE_BITS-1:0] dac_code_o,
  output logic [NUM_CHANNELS-1:0][CODE_BITS-1:0] input_code_o,
  output logic word_seen_o,
  output logic [7:0] word_count_o
);

  // ----------------------------------------------------------------
  // Serial side, clocked by the link clock
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] shift_q;
  logic [BIT_CNT_W-1:0] bit_cnt_q;
  logic [WORD_BITS-1:0] word_q;
  logic word_tgl_q;

  wire last_bit = (bit_cnt_q == LAST_BIT_IDX);
  wire [WORD_BITS-1:0] shift_d = {shift_q[WORD_BITS-2:0], link.sdi};

  // Data enters at the LSB, so the first bit ends up at bit 23
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_q <= '0;
    end else if (!link.cs_n) begin
      shift_q <= shift_d;
    end
  end

  // Bit position restarts whenever select is released
  always_ff @(posedge link.sclk or negedge rst_n_i or posedge link.cs_n) begin
    if (!rst_n_i) begin
      bit_cnt_q <= '0;
    end else if (link.cs_n) begin
      bit_cnt_q <= '0;
    end else begin
      bit_cnt_q <= last_bit ? '0 : bit_cnt_q + 1'b1;
    end
  end

  // A complete word is held stable and announced by a toggle
  always_ff @(posedge link.sclk or negedge rst_n_i) begin
    if (!rst_n_i) begin
      word_q <= '0;
      word_tgl_q <= 1'b0;
    end else if (!link.cs_n && last_bit) begin
      word_q <= shift_d;
      word_tgl_q <= ~word_tgl_q;
    end
  end

  // ----------------------------------------------------------------
  // Pin synchronisers into the core clock
  // ----------------------------------------------------------------
  // The toggle crosses alone; word_q is already stable when it lands
  // and does not move again for another 24 serial clocks
  localparam int SYNC_W = 5;
  localparam int S_TGL = 4;
  localparam int S_LOAD = 3;
  localparam int S_UPD = 2;
  localparam int S_RST = 1;
  localparam int S_RSEL = 0;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 5'h0F;

  logic [SYNC_W-1:0] sync1_q;
  logic [SYNC_W-1:0] sync2_q;
  logic tgl_seen_q;
  logic upd_seen_q;

  wire [SYNC_W-1:0] pins_raw = {word_tgl_q, link.load_n, link.output_update_strobe,
                                link.reset_n, link.reset_level_select};

  // Reset values match the idle pin levels, so no false edge follows reset
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= SYNC_RESET;
      sync2_q <= SYNC_RESET;
      tgl_seen_q <= 1'b0;
      upd_seen_q <= 1'b1;
    end else if (ce_i) begin
      sync1_q <= pins_raw;
      sync2_q <= sync1_q;
      tgl_seen_q <= sync2_q[S_TGL];
      upd_seen_q <= sync2_q[S_UPD];
    end
  end

  wire word_arrived = sync2_q[S_TGL] ^ tgl_seen_q;
  wire load_active = !sync2_q[S_LOAD];
  wire update_rise = sync2_q[S_UPD] && !upd_seen_q;
  wire reset_active = !sync2_q[S_RST];
  wire [CODE_BITS-1:0] reset_code = sync2_q[S_RSEL] ? MIDSCALE_CODE : ZEROSCALE_CODE;

  // ----------------------------------------------------------------
  // Latest received word in the core clock
  // ----------------------------------------------------------------
  logic [WORD_BITS-1:0] latest_q;
  logic seen_q;
  logic [7:0] count_q;

  // Counts every complete word and wraps at 256
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      latest_q <= '0;
      seen_q <= 1'b0;
      count_q <= 8'h00;
    end else if (ce_i) begin
      seen_q <= word_arrived;
      if (word_arrived) begin
        latest_q <= word_q;
        count_q <= count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Channel selection
  // ----------------------------------------------------------------
  function automatic logic chan_hit(input logic [WORD_BITS-1:0] w, input int ch);
    logic [1:0] addr;
    addr = {w[CHANNEL_ADDR_HI_POS], w[CHANNEL_ADDR_LO_POS]};
    // Broadcast overrides the address; otherwise only a match loads
    chan_hit = w[BROADCAST_POS] || (addr == 2'(ch));
  endfunction

  // Bits 20..16 are never looked at
  wire [CODE_BITS-1:0] latest_code = latest_q[CODE_MSB_POS:0];

  // ----------------------------------------------------------------
  // Input and output registers, one pair per channel
  // ----------------------------------------------------------------
  logic [NUM_CHANNELS-1:0][CODE_BITS-1:0] in_q;
  logic [NUM_CHANNELS-1:0][CODE_BITS-1:0] out_q;

  // Clock enable freezes the core registers; the serial side keeps running
  // Pin reset outranks both the load strobe and the update edge
  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_chan
      wire hit = chan_hit(latest_q, ch);

      // Transparent while the load strobe is low
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          in_q[ch] <= MIDSCALE_CODE;
        end else if (ce_i) begin
          if (reset_active) begin
            in_q[ch] <= reset_code;
          end else if (load_active && hit) begin
            in_q[ch] <= latest_code;
          end
        end
      end

      // All channels take their input register on one edge
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          out_q[ch] <= MIDSCALE_CODE;
        end else if (ce_i) begin
          if (reset_active) begin
            out_q[ch] <= reset_code;
          end else if (update_rise) begin
            out_q[ch] <= in_q[ch];
          end
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign dac_code_o = out_q;
  assign input_code_o = in_q;
  assign word_seen_o = seen_q;
  assign word_count_o = count_q;
endmodule
`default_nettype wire

/* dac_link_sva.sv */
// Checker for the serial link between the host end and the converter end
`timescale 1ns/1ns
`default_nettype none
module dac_link_sva
  import dac_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic sdi,
  input wire logic load_n,
  input wire logic output_update_strobe,
  input wire logic reset_n,
  input wire logic reset_level_select
);
  localparam int HALF_LO = SCLK_HALF_CYC - 1;
  localparam int HALF_HI = SCLK_HALF_CYC + 1;
  logic sclk_q;
  logic [7:0] lo_cnt_q;
  logic [7:0] lo_cnt_d;
  logic [5:0] rise_cnt_q;
  logic [5:0] rise_cnt_d;
  wire logic sclk_rise;
  localparam logic [11:0] GAP_MAX_CNT = 12'h514;
  logic load_q;
  logic gap_run_q;
  logic gap_run_d;
  logic [11:0] gap_cnt_q;
  logic [11:0] gap_cnt_d;
  wire logic load_rise;

  // ----------------------------------------------------------------
  // Helper counters: serial clock low time and rises per frame
  // ----------------------------------------------------------------
  assign sclk_rise = sclk & ~sclk_q;
  assign lo_cnt_d = sclk ? 8'h00 : lo_cnt_q + 8'h01;
  assign rise_cnt_d = cs_n ? 6'h00 : rise_cnt_q + {5'h00, sclk_rise};
  // Cycles from the end of the load pulse until the update strobe falls
  assign load_rise = load_n & ~load_q;
  assign gap_run_d = load_rise | (gap_run_q & output_update_strobe);
  assign gap_cnt_d = (load_rise || !gap_run_q) ? 12'h000 : gap_cnt_q + {11'h000, gap_cnt_q != 12'hFFF};
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 1'b1;
      lo_cnt_q <= 8'h00;
      rise_cnt_q <= 6'h00;
      load_q <= 1'b1;
      gap_run_q <= 1'b0;
      gap_cnt_q <= 12'h000;
    end else begin
      sclk_q <= sclk;
      lo_cnt_q <= lo_cnt_d;
      rise_cnt_q <= rise_cnt_d;
      load_q <= load_n;
      gap_run_q <= gap_run_d;
      gap_cnt_q <= gap_cnt_d;
    end
  end

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_sclk_idle; cs_n |-> sclk; endproperty
  property p_sclk_low_time; $rose(sclk) |-> lo_cnt_q inside {[HALF_LO:HALF_HI]}; endproperty
  property p_sdi_stable; $rose(sclk) |-> $stable(sdi); endproperty
  property p_word_bits; $rose(cs_n) |-> rise_cnt_q == 6'(WORD_BITS); endproperty
  property p_load_idle_frame; !cs_n |-> load_n; endproperty
  property p_load_after_frame; $rose(cs_n) |-> ##[0:2] !load_n; endproperty
  property p_load_width; $fell(load_n) |-> !load_n [*8]; endproperty
  property p_update_after_load; $rose(load_n) |-> output_update_strobe [*8]; endproperty
  property p_update_gap; gap_run_q |-> gap_cnt_q <= GAP_MAX_CNT; endproperty
  property p_unused_zero; $rose(sclk) && (rise_cnt_q inside {[6'h03:6'h07]}) |-> !sdi; endproperty
  property p_update_apart; !load_n |-> output_update_strobe && cs_n; endproperty
  property p_reset_pins; reset_n && reset_level_select; endproperty

  a_sclk_idle: assert property (p_sclk_idle) else $error("serial clock low outside frame");
  a_sclk_low_time: assert property (p_sclk_low_time) else $error("serial clock low time off");
  a_sdi_stable: assert property (p_sdi_stable) else $error("data changed at clock rise");
  a_word_bits: assert property (p_word_bits) else $error("frame not 24 clock rises");
  a_load_idle_frame: assert property (p_load_idle_frame) else $error("load low while shifting");
  a_load_after_frame: assert property (p_load_after_frame) else $error("no load after frame");
  a_load_width: assert property (p_load_width) else $error("load pulse too short");
  a_update_after_load: assert property (p_update_after_load) else $error("update not after load");
  a_update_gap: assert property (p_update_gap) else $error("update late after load");
  a_unused_zero: assert property (p_unused_zero) else $error("unused bit sent as one");
  a_update_apart: assert property (p_update_apart) else $error("update overlaps load");
  a_reset_pins: assert property (p_reset_pins) else $error("reset pins not held high");

  c_frame: cover property ($rose(cs_n));
  c_load: cover property ($rose(load_n));
  c_update: cover property ($rose(output_update_strobe));
endmodule
`default_nettype wire

/* quad_dac_serial_load_control_tb.sv */
// Self-checking bench for the host and converter ends joined by the link
`timescale 1ns/1ns
`default_nettype none
module quad_dac_serial_load_control_tb;
  import dac_pkg::*;
  logic clk_i;
  logic rst_n_i;
  logic word_valid_i;
  logic [1:0] channel_addr_i;
  logic broadcast_i;
  logic [CODE_BITS-1:0] code_i;
  logic word_ready_o;
  logic done_o;
  logic busy_o;
  logic word_seen_o;
  logic [CHANNELS-1:0][CODE_BITS-1:0] dac_code_o;
  logic [CHANNELS-1:0][CODE_BITS-1:0] input_code_o;
  logic [7:0] word_count_o;
  logic [CODE_BITS-1:0] exp_code [CHANNELS];
  int miscompares;
  int n_compared;

  // ----------------------------------------------------------------
  // Clock, ends and checker
  // ----------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  dac_link_if link();
  host_ctrl u_host_ctrl (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .word_valid_i(word_valid_i),
    .word_ready_o(word_ready_o), .channel_addr_i(channel_addr_i), .broadcast_i(broadcast_i),
    .code_i(code_i), .busy_o(busy_o), .done_o(done_o), .link(link));
  quad_dac_device u_quad_dac_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1), .link(link),
    .dac_code_o(dac_code_o), .input_code_o(input_code_o), .word_seen_o(word_seen_o), .word_count_o(word_count_o));
  dac_link_sva u_dac_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .sclk(link.sclk), .cs_n(link.cs_n),
    .sdi(link.sdi), .load_n(link.load_n), .output_update_strobe(link.output_update_strobe),
    .reset_n(link.reset_n), .reset_level_select(link.reset_level_select));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic print_verdict();
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic push(input logic [1:0] a, input logic b, input logic [15:0] c);
    int n;
    word_valid_i = 1'b1;
    channel_addr_i = a;
    broadcast_i = b;
    code_i = c;
    for (n = 0; n < 20000 && word_ready_o !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    @(posedge clk_i);
    #1;
    word_valid_i = 1'b0;
    @(posedge clk_i);
    #1;
  endtask

  task automatic wait_done(input int k);
    int n;
    for (n = 0; n < 20000 && k > 0; n++) begin
      @(posedge clk_i);
      #1;
      if (done_o === 1'b1) k--;
    end
    repeat (4) @(posedge clk_i);
    #1;
    check(k[15:0], 16'h0000);
  endtask

  task automatic check_all();
    for (int ch = 0; ch < CHANNELS; ch++) begin
      check(dac_code_o[ch], exp_code[ch]);
      check(input_code_o[ch], exp_code[ch]);
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    for (int ch = 0; ch < CHANNELS; ch++) exp_code[ch] = MIDSCALE_CODE;
    check_all();
    check({8'h00, word_count_o}, 16'h0000);
  endtask

  task automatic t_single();
    logic [15:0] codes [4];
    int n;
    codes = '{16'h0000, 16'hFFFF, 16'h8001, 16'h7FFE};
    for (int a = 0; a < CHANNELS; a++) begin
      push(a[1:0], 1'b0, codes[a]);
      for (n = 0; n < 3000 && word_seen_o !== 1'b1; n++) begin
        @(posedge clk_i);
        #1;
      end
      check({15'h0000, word_seen_o}, 16'h0001);
      for (n = 0; n < 3000 && input_code_o[a] !== codes[a]; n++) begin
        @(posedge clk_i);
        #1;
      end
      check(input_code_o[a], codes[a]);
      check({15'h0000, busy_o}, 16'h0001);
      check(dac_code_o[a], exp_code[a]);
      exp_code[a] = codes[a];
      wait_done(1);
      check_all();
    end
  endtask

  task automatic t_broadcast();
    push(2'h1, 1'b1, 16'hA5C3);
    wait_done(1);
    for (int ch = 0; ch < CHANNELS; ch++) exp_code[ch] = 16'hA5C3;
    check_all();
    check({15'h0000, busy_o}, 16'h0000);
  endtask

  task automatic t_burst();
    push(2'h3, 1'b0, 16'h0F0F);
    push(2'h0, 1'b0, 16'hF0F0);
    push(2'h2, 1'b0, 16'h3C3C);
    check({15'h0000, word_ready_o}, 16'h0000);
    wait_done(3);
    exp_code[3] = 16'h0F0F;
    exp_code[0] = 16'hF0F0;
    exp_code[2] = 16'h3C3C;
    check_all();
    check({8'h00, word_count_o}, 16'h0008);
  endtask

  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    miscompares = 0;
    n_compared = 0;
    rst_n_i = 1'b0;
    word_valid_i = 1'b0;
    channel_addr_i = 2'h0;
    broadcast_i = 1'b0;
    code_i = 16'h0000;
    repeat (3) @(posedge clk_i);
    #1;
    rst_n_i = 1'b1;
    t_reset();
    t_single();
    t_broadcast();
    t_burst();
    print_verdict();
  end

  initial begin
    #320000;
    miscompares++;
    print_verdict();
  end
endmodule
`default_nettype wire
